// ### ssx_core.sv
// execution core: avalon slave, accumulator, flags, direction regs, sleep
`default_nettype none
module ssx_core (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        wake,
	input  wire logic        wdt_tick,
	output logic             osc_run,
	output logic [7:0]       port_a_direction,
	output logic [7:0]       port_b_direction,
	output logic [7:0]       port_c_direction
);
	typedef enum {ST_IDLE, ST_EXEC, ST_ACK} ssx_state_t;

	ssx_state_t          state_q;
	ssx_pkg::ssx_cmd_t   cmd_q;
	ssx_pkg::ssx_flags_t flags_q;
	ssx_pkg::ssx_flags_t alu_flags;
	logic [7:0]          acc_q;
	logic [7:0]          dir_a_q;
	logic [7:0]          dir_b_q;
	logic [7:0]          dir_c_q;
	logic                pd_q;
	logic                to_q;
	logic                sleep_q;
	logic [7:0]          wdt_q;
	logic [7:0]          pre_q;
	logic [31:0]         rdata_q;
	logic [7:0]          alu_result;
	logic [7:0]          freg_rdata;
	logic [7:0]          operand;
	logic                exec;
	logic                is_lit;
	logic                to_freg;
	logic                writes_result;
	logic                fwe;
	logic [6:0]          fwaddr;
	logic [7:0]          fwdata;
	logic                host_fwe;
	logic                cmd_wr;

	function automatic logic uses_dest(input ssx_pkg::ssx_op_t op);
		return op == ssx_pkg::OP_REG_SUB || op == ssx_pkg::OP_REG_SUBB ||
			op == ssx_pkg::OP_NIB_SWAP || op == ssx_pkg::OP_REG_XOR;
	endfunction

	// command write launches an operation; bus holds off until it is done
	assign cmd_wr = (state_q == ST_IDLE) && avs_write && avs_address == ssx_pkg::ADDR_CMD
		&& avs_byteenable[0];
	assign exec = (state_q == ST_EXEC);
	assign avs_waitrequest = (avs_read || avs_write) && state_q != ST_ACK;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_wr) begin
						state_q <= ST_EXEC;
					end else if (avs_read || avs_write) begin
						state_q <= ST_ACK;
					end
				end
				ST_EXEC: state_q <= ST_ACK;
				ST_ACK: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmd_q <= '0;
		end else if (cmd_wr) begin
			cmd_q.op    <= ssx_pkg::ssx_op_t'(avs_writedata[ssx_pkg::CMD_OP_LSB +: 3]);
			cmd_q.dest  <= avs_writedata[ssx_pkg::CMD_DEST_BIT];
			cmd_q.faddr <= avs_writedata[ssx_pkg::CMD_ADDR_LSB +: 7];
			cmd_q.lit   <= avs_writedata[ssx_pkg::CMD_LIT_LSB +: 8];
		end
	end

	assign is_lit = cmd_q.op == ssx_pkg::OP_LIT_SUB || cmd_q.op == ssx_pkg::OP_LIT_XOR;
	assign operand = is_lit ? cmd_q.lit : freg_rdata;
	assign writes_result = cmd_q.op != ssx_pkg::OP_DIR_LOAD && cmd_q.op != ssx_pkg::OP_SLEEP;
	assign to_freg = uses_dest(cmd_q.op) && cmd_q.dest;

	ssx_alu u_alu (
		.op        (cmd_q.op),
		.acc       (acc_q),
		.operand   (operand),
		.flags_in  (flags_q),
		.flags_out (alu_flags),
		.result    (alu_result)
	);

	// software may also poke a file register directly through the data window
	assign host_fwe = (state_q == ST_IDLE) && avs_write && avs_address == ssx_pkg::ADDR_FREG
		&& avs_byteenable[0];
	assign fwe = (exec && writes_result && to_freg) || host_fwe;
	assign fwaddr = host_fwe ? avs_writedata[ssx_pkg::WIN_ADDR_LSB +: 7] : cmd_q.faddr;
	assign fwdata = host_fwe ? avs_writedata[7:0] : alu_result;

	ssx_regfile #(
		.DEPTH (128)
	) u_rf (
		.clock (clock),
		.nrst  (nrst),
		.raddr (exec ? cmd_q.faddr : avs_writedata[ssx_pkg::WIN_ADDR_LSB +: 7]),
		.rdata (freg_rdata),
		.we    (fwe),
		.waddr (fwaddr),
		.wdata (fwdata)
	);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			acc_q <= ssx_pkg::RST_ACC;
		end else if (exec && writes_result && !to_freg) begin
			acc_q <= alu_result;
		end else if (state_q == ST_IDLE && avs_write && avs_address == ssx_pkg::ADDR_ACC
				&& avs_byteenable[0]) begin
			acc_q <= avs_writedata[7:0];
		end
	end

	// the alu passes flags through untouched for swap
	always_ff @(posedge clock) begin
		if (!nrst) begin
			flags_q <= '0;
		end else if (exec) begin
			flags_q <= alu_flags;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			dir_a_q <= ssx_pkg::RST_DIR;
			dir_b_q <= ssx_pkg::RST_DIR;
			dir_c_q <= ssx_pkg::RST_DIR;
		end else if (exec && cmd_q.op == ssx_pkg::OP_DIR_LOAD) begin
			// other operands are ignored: no direction register there
			case (cmd_q.faddr[2:0])
				ssx_pkg::DIR_SEL_A: dir_a_q <= acc_q;
				ssx_pkg::DIR_SEL_B: dir_b_q <= acc_q;
				ssx_pkg::DIR_SEL_C: dir_c_q <= acc_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			pd_q <= ssx_pkg::RST_PD;
			to_q <= ssx_pkg::RST_TO;
		end else if (exec && cmd_q.op == ssx_pkg::OP_SLEEP) begin
			pd_q <= 1'b0;
			to_q <= 1'b1;
		end
	end

	// watchdog: prescaler divides ticks; only its clear is ours to honour
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wdt_q <= ssx_pkg::WDT_CLEAR;
			pre_q <= ssx_pkg::PRE_CLEAR;
		end else if (exec && cmd_q.op == ssx_pkg::OP_SLEEP) begin
			wdt_q <= ssx_pkg::WDT_CLEAR;
			pre_q <= ssx_pkg::PRE_CLEAR;
		end else if (wdt_tick) begin
			pre_q <= pre_q + 8'h01;
			if (pre_q == 8'hff) begin
				wdt_q <= wdt_q + 8'h01;
			end
		end
	end

	// wake beats sleep entry only after sleep is taken
	always_ff @(posedge clock) begin
		if (!nrst) begin
			sleep_q <= 1'b0;
		end else if (exec && cmd_q.op == ssx_pkg::OP_SLEEP) begin
			sleep_q <= 1'b1;
		end else if (wake) begin
			sleep_q <= 1'b0;
		end
	end
	assign osc_run = ~sleep_q;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else if (state_q == ST_IDLE && avs_read) begin
			case (avs_address)
				ssx_pkg::ADDR_ACC: rdata_q <= {24'h000000, acc_q};
				ssx_pkg::ADDR_STATUS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[ssx_pkg::ST_CARRY] <= flags_q.carry;
					rdata_q[ssx_pkg::ST_HALF]  <= flags_q.half;
					rdata_q[ssx_pkg::ST_ZERO]  <= flags_q.zero;
					rdata_q[ssx_pkg::ST_PD]    <= pd_q;
					rdata_q[ssx_pkg::ST_TO]    <= to_q;
					rdata_q[ssx_pkg::ST_SLEEP] <= sleep_q;
				end
				ssx_pkg::ADDR_DIR_A: rdata_q <= {24'h000000, dir_a_q};
				ssx_pkg::ADDR_DIR_B: rdata_q <= {24'h000000, dir_b_q};
				ssx_pkg::ADDR_DIR_C: rdata_q <= {24'h000000, dir_c_q};
				ssx_pkg::ADDR_FREG:  rdata_q <= {24'h000000, freg_rdata};
				ssx_pkg::ADDR_WDT:   rdata_q <= {16'h0000, pre_q, wdt_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign avs_readdata = rdata_q;

	assign port_a_direction = dir_a_q;
	assign port_b_direction = dir_b_q;
	assign port_c_direction = dir_c_q;

	sub_carry_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_REG_SUB |=> flags_q.carry == ($past(acc_q) <= $past(operand)))
		else $error("carry wrong after subtract");
	half_flag_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_LIT_SUB |=>
		flags_q.half == ($past(acc_q[3:0]) <= $past(cmd_q.lit[3:0])))
		else $error("half flag wrong after subtract");
	lit_sub_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_LIT_SUB |=> acc_q == 8'($past(cmd_q.lit) - $past(acc_q)))
		else $error("literal subtract result wrong");
	zero_flag_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_LIT_XOR |=> flags_q.zero == (acc_q == 8'h00))
		else $error("zero flag disagrees with result");
	swap_flags_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_NIB_SWAP |=> $stable(flags_q))
		else $error("swap changed flags");
	sleep_status_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_SLEEP |=> !pd_q && to_q && !osc_run && wdt_q == 8'h00)
		else $error("sleep entry status wrong");
	dir_load_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_DIR_LOAD && cmd_q.faddr[2:0] == ssx_pkg::DIR_SEL_B |=>
		port_b_direction == $past(acc_q) && $stable(flags_q))
		else $error("direction load wrong");
	xor_dest_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_REG_XOR && cmd_q.dest |=> $stable(acc_q))
		else $error("register xor touched accumulator");
	bus_ack_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(avs_read) |-> ##[1:3] !avs_waitrequest)
		else $error("read not answered in time");
	bus_wr_ack_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(avs_write) |-> ##[1:3] !avs_waitrequest)
		else $error("write not answered in time");
	subb_result_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_REG_SUBB && !cmd_q.dest |=>
		acc_q == 8'($past(operand) - $past(acc_q) - {7'h00, ~$past(flags_q.carry)}))
		else $error("borrow subtract result wrong");
	sub_dest_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_REG_SUB && cmd_q.dest |=> $stable(acc_q))
		else $error("register subtract touched accumulator");
	swap_result_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_NIB_SWAP && !cmd_q.dest |=>
		acc_q == {$past(operand[3:0]), $past(operand[7:4])})
		else $error("swap result wrong");
	lit_xor_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_LIT_XOR |=> acc_q == ($past(acc_q) ^ $past(cmd_q.lit))
		&& flags_q.carry == $past(flags_q.carry) && flags_q.half == $past(flags_q.half))
		else $error("literal xor wrong");
	wdt_clear_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_SLEEP |=> wdt_q == ssx_pkg::WDT_CLEAR
		&& pre_q == ssx_pkg::PRE_CLEAR)
		else $error("watchdog not cleared by sleep");
	sleep_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		!osc_run && !wake |=> !osc_run)
		else $error("oscillator restarted without wake");
	dir_c_load_a: assert property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_DIR_LOAD && cmd_q.faddr[2:0] == ssx_pkg::DIR_SEL_C
		|=> port_c_direction == $past(acc_q) && $stable(port_a_direction))
		else $error("direction load to port c wrong");

	sleep_c: cover property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_SLEEP);
	xor_zero_c: cover property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_LIT_XOR && alu_flags.zero);
	dir_load_c: cover property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_DIR_LOAD);
	subb_c: cover property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_REG_SUBB && !flags_q.carry);
	swap_c: cover property (@(posedge clock) disable iff (!nrst)
		exec && cmd_q.op == ssx_pkg::OP_NIB_SWAP && cmd_q.dest);
endmodule
`default_nettype wire

// ### ssx_pkg.sv
// package for the subtract/swap/xor/sleep execution block
`default_nettype none
package ssx_pkg;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;

	// register map (byte addresses, word aligned)
	localparam logic [5:0] ADDR_CMD    = 6'h00;
	localparam logic [5:0] ADDR_ACC    = 6'h04;
	localparam logic [5:0] ADDR_STATUS = 6'h08;
	localparam logic [5:0] ADDR_DIR_A  = 6'h0c;
	localparam logic [5:0] ADDR_DIR_B  = 6'h10;
	localparam logic [5:0] ADDR_DIR_C  = 6'h14;
	localparam logic [5:0] ADDR_FREG   = 6'h18;
	localparam logic [5:0] ADDR_WDT    = 6'h1c;

	// command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_DEST_BIT = 3;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_LIT_LSB  = 16;
	localparam int WIN_ADDR_LSB = 9;

	// status fields
	localparam int ST_CARRY = 0;
	localparam int ST_HALF  = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_PD    = 3;
	localparam int ST_TO    = 4;
	localparam int ST_SLEEP = 5;
	localparam int ST_BUSY  = 6;

	localparam logic [7:0] RST_ACC    = 8'h00;
	localparam logic [7:0] RST_DIR    = 8'hff;
	localparam logic       RST_PD     = 1'b1;
	localparam logic       RST_TO     = 1'b1;
	localparam logic [7:0] WDT_CLEAR  = 8'h00;
	localparam logic [7:0] PRE_CLEAR  = 8'h00;

	localparam logic [2:0] DIR_SEL_A = 3'h5;
	localparam logic [2:0] DIR_SEL_B = 3'h6;
	localparam logic [2:0] DIR_SEL_C = 3'h7;

	typedef enum logic [2:0] {
		OP_LIT_SUB,
		OP_REG_SUB,
		OP_REG_SUBB,
		OP_NIB_SWAP,
		OP_DIR_LOAD,
		OP_LIT_XOR,
		OP_REG_XOR,
		OP_SLEEP
	} ssx_op_t;

	typedef struct packed {
		ssx_op_t          op;
		logic             dest;
		logic [6:0]       faddr;
		logic [7:0]       lit;
	} ssx_cmd_t;

	typedef struct packed {
		logic       carry;
		logic       half;
		logic       zero;
	} ssx_flags_t;
endpackage
`default_nettype wire

// ### ssx_alu.sv
// combinational arithmetic for subtract, swap and xor
`default_nettype none
module ssx_alu (
	input  wire ssx_pkg::ssx_op_t   op,
	input  wire logic [7:0]         acc,
	input  wire logic [7:0]         operand,
	input  wire ssx_pkg::ssx_flags_t flags_in,
	output ssx_pkg::ssx_flags_t     flags_out,
	output logic [7:0]              result
);
	logic [8:0] diff;
	logic [4:0] ldiff;
	logic       bin;

	always_comb begin
		// subtract with borrow takes the inverted carry as borrow-in
		bin = (op == ssx_pkg::OP_REG_SUBB) ? ~flags_in.carry : 1'b0;
		diff = {1'b0, operand} - {1'b0, acc} - {8'h00, bin};
		ldiff = {1'b0, operand[3:0]} - {1'b0, acc[3:0]} - {4'h0, bin};
		flags_out = flags_in;
		result = 8'h00;
		case (op)
			ssx_pkg::OP_LIT_SUB, ssx_pkg::OP_REG_SUB, ssx_pkg::OP_REG_SUBB: begin
				result = diff[7:0];
				flags_out.carry = ~diff[8];
				flags_out.half = ~ldiff[4];
				flags_out.zero = (diff[7:0] == 8'h00);
			end
			ssx_pkg::OP_NIB_SWAP: begin
				result = {operand[3:0], operand[7:4]};
			end
			ssx_pkg::OP_LIT_XOR, ssx_pkg::OP_REG_XOR: begin
				result = acc ^ operand;
				flags_out.zero = ((acc ^ operand) == 8'h00);
			end
			default: begin
				result = acc;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### ssx_regfile.sv
// file register storage, 128 bytes of flip-flops
`default_nettype none
module ssx_regfile #(
	parameter int DEPTH = 128
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic [6:0] raddr,
	output logic [7:0]      rdata,
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata
);
	logic [7:0] mem_q [DEPTH];

	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_cell
			always_ff @(posedge clock) begin
				if (!nrst) begin
					mem_q[i] <= 8'h00;
				end else if (we && waddr == 7'(i)) begin
					mem_q[i] <= wdata;
				end
			end
		end
	endgenerate

	assign rdata = mem_q[raddr];
endmodule
`default_nettype wire

// ### ssx_tb.sv
// self-checking bench for the subtract, swap, xor and sleep core
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock          = 1'b0;
	logic        nrst           = 1'b0;
	logic [5:0]  avs_address    = 6'h00;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic        wake           = 1'b0;
	logic        wdt_tick       = 1'b0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        osc_run;
	logic [7:0]  port_a_direction;
	logic [7:0]  port_b_direction;
	logic [7:0]  port_c_direction;
	logic [31:0] rd;
	logic [10:0] e;
	logic [2:0]  fl;
	logic        c;
	logic [6:0]  fa;
	int          failures = 0;
	int          checks   = 0;
	int          n;
	localparam logic [7:0] TW [6] = '{8'h05, 8'h06, 8'h10, 8'h00, 8'hff, 8'h3c};
	localparam logic [7:0] TK [6] = '{8'h05, 8'h05, 8'h0f, 8'h00, 8'h00, 8'hc3};

	ssx_core u_dut (
		.clock            (clock),
		.nrst             (nrst),
		.avs_address      (avs_address),
		.avs_read         (avs_read),
		.avs_write        (avs_write),
		.avs_writedata    (avs_writedata),
		.avs_byteenable   (avs_byteenable),
		.avs_readdata     (avs_readdata),
		.avs_waitrequest  (avs_waitrequest),
		.wake             (wake),
		.wdt_tick         (wdt_tick),
		.osc_run          (osc_run),
		.port_a_direction (port_a_direction),
		.port_b_direction (port_b_direction),
		.port_c_direction (port_c_direction)
	);

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic wrap_up();
		if (failures == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until the edge that sees waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clock);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic exec(input ssx_pkg::ssx_op_t op, input logic d, input logic [6:0] a,
		input logic [7:0] k);
		bus(1'b1, ssx_pkg::ADDR_CMD, {8'h00, k, 1'b0, a, 4'h0, d, op});
	endtask

	task automatic setf(input logic [6:0] a, input logic [7:0] v);
		bus(1'b1, ssx_pkg::ADDR_FREG, {16'h0, a, 1'b0, v});
	endtask

	task automatic setw(input logic [7:0] v);
		bus(1'b1, ssx_pkg::ADDR_ACC, {24'h0, v});
	endtask

	task automatic stat();
		bus(1'b0, ssx_pkg::ADDR_STATUS, 32'h0);
	endtask

	// result lands in the register or the accumulator, the other stays put
	task automatic route(input logic d, input logic [6:0] a, input logic [7:0] r,
		input logic [7:0] w0, input logic [7:0] f0);
		bus(1'b0, ssx_pkg::ADDR_FREG, {16'h0, a, 9'h0});
		check(rd, {24'h0, d ? r : f0});
		bus(1'b0, ssx_pkg::ADDR_ACC, 32'h0);
		check(rd, {24'h0, d ? w0 : r});
	endtask

	// {zero, half, carry, result}; carry and half mean no borrow
	function automatic logic [10:0] sref(input logic [7:0] a, input logic [7:0] w,
		input logic b);
		logic [8:0] t;
		t = {1'b0, a} - {1'b0, w} - {8'h0, b};
		return {t[7:0] == 8'h00, ({1'b0, w[3:0]} + {4'h0, b}) <= {1'b0, a[3:0]}, ~t[8], t[7:0]};
	endfunction

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		check({7'h00, osc_run, port_a_direction, port_b_direction, port_c_direction},
			32'h01ffffff);
		stat();
		check(rd, 32'h18);
		for (int i = 0; i < 6; i++) begin
			setw(TW[i]);
			exec(ssx_pkg::OP_LIT_SUB, 1'b0, 7'h00, TK[i]);
			e = sref(TK[i], TW[i], 1'b0);
			route(1'b0, 7'h00, e[7:0], TW[i], 8'h00);
			stat();
			check(32'(rd[2:0]), 32'(e[10:8]));
			fa = 7'(127 - 25 * i);
			setf(fa, TK[i]);
			setw(TW[i]);
			exec(ssx_pkg::OP_REG_SUB, i[0], fa, 8'h00);
			e = sref(TK[i], TW[i], 1'b0);
			c = e[8];
			route(i[0], fa, e[7:0], TW[i], TK[i]);
			stat();
			check(32'(rd[2:0]), 32'(e[10:8]));
			setf(fa, TK[i]);
			setw(TW[i]);
			exec(ssx_pkg::OP_REG_SUBB, ~i[0], fa, 8'h00);
			e = sref(TK[i], TW[i], ~c);
			route(~i[0], fa, e[7:0], TW[i], TK[i]);
			stat();
			check(32'(rd[2:0]), 32'(e[10:8]));
		end
		for (int d = 0; d < 2; d++) begin
			setf(7'h09, 8'h3c);
			setw(8'h81);
			stat();
			fl = rd[2:0];
			exec(ssx_pkg::OP_NIB_SWAP, d[0], 7'h09, 8'h00);
			route(d[0], 7'h09, 8'hc3, 8'h81, 8'h3c);
			stat();
			check(32'(rd[2:0]), 32'(fl));
		end
		for (int k = 0; k < 3; k++) begin
			setw(8'(8'h21 * (k + 1)));
			exec(ssx_pkg::OP_DIR_LOAD, 1'b0, 7'(5 + k), 8'h00);
			bus(1'b0, 6'(ssx_pkg::ADDR_DIR_A + 4 * k), 32'h0);
			check(rd, 32'(8'h21 * (k + 1)));
			stat();
			check(32'(rd[2:0]), 32'(fl));
		end
		check({8'h0, port_a_direction, port_b_direction, port_c_direction},
			32'h00214263);
		setw(8'h5a);
		exec(ssx_pkg::OP_LIT_XOR, 1'b0, 7'h00, 8'h5a);
		route(1'b0, 7'h00, 8'h00, 8'h5a, 8'h00);
		stat();
		check(32'({1'b1, fl[1:0]}), 32'(rd[2:0]));
		setf(7'h03, 8'h0f);
		setw(8'hf0);
		exec(ssx_pkg::OP_REG_XOR, 1'b1, 7'h03, 8'h00);
		route(1'b1, 7'h03, 8'hff, 8'hf0, 8'h0f);
		stat();
		check(32'(rd[2:0]), 32'({1'b0, fl[1:0]}));
		// lane 0 disabled: the accumulator must not change
		avs_byteenable <= 4'he;
		setw(8'h77);
		avs_byteenable <= 4'hf;
		bus(1'b0, ssx_pkg::ADDR_ACC, 32'h0);
		check(rd, 32'hf0);
		bus(1'b1, 6'h24, 32'hff);
		bus(1'b0, 6'h20, 32'h0);
		check(rd, 32'h0);
		exec(ssx_pkg::OP_REG_XOR, 1'b0, 7'h03, 8'h00);
		route(1'b0, 7'h03, 8'h0f, 8'hf0, 8'hff);
		// let the prescaler and watchdog run so the clear is visible
		wdt_tick <= 1'b1;
		repeat (300) @(posedge clock);
		wdt_tick <= 1'b0;
		bus(1'b0, ssx_pkg::ADDR_WDT, 32'h0);
		check(rd, 32'h0000_2c01);
		exec(ssx_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00);
		stat();
		check(32'(rd[5:3]), 32'h6);
		check(32'(osc_run), 32'h0);
		bus(1'b0, ssx_pkg::ADDR_WDT, 32'h0);
		check(rd, 32'h0);
		wake <= 1'b1;
		for (n = 0; n < 20 && osc_run !== 1'b1; n++) begin
			@(posedge clock);
		end
		wake <= 1'b0;
		check(32'(osc_run), 32'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
